/* File: common/onchip_flash_pkg.sv */
// Purpose: shared constants and types of the on-chip flash controller
// Assumes: 32-bit Avalon-MM register bus, byte addresses, one word per register
// Notes:   offsets and bit positions are used by the design and the bench alike
package onchip_flash_pkg;
	// ==========================================================
	// geometry
	localparam int DEF_FLASH_KB = 8;
	localparam int MIN_FLASH_KB = 8;
	localparam int MAX_FLASH_KB = 256;
	localparam int BLOCK_BYTES  = 1024;
	localparam int UNIT_BYTES   = 2048;
	localparam int WORD_BYTES   = 4;
	localparam int KB_BYTES     = 1024;
	// ==========================================================
	// timing: pulse widths in microseconds, reset value of clocks per microsecond
	localparam int DEF_ERASE_US = 20;
	localparam int DEF_PROG_US  = 2;
	localparam logic [7:0] USEC_RST = 8'h14;
	// ==========================================================
	// register offsets (byte addresses)
	localparam logic [7:0] OFS_ADDR = 8'h00;
	localparam logic [7:0] OFS_DATA = 8'h04;
	localparam logic [7:0] OFS_CMD  = 8'h08;
	localparam logic [7:0] OFS_STAT = 8'h0C;
	localparam logic [7:0] OFS_USEC = 8'h10;
	localparam logic [7:0] OFS_RAW  = 8'h14;
	localparam logic [7:0] OFS_EN   = 8'h18;
	localparam logic [7:0] OFS_MSK  = 8'h1C;
	localparam logic [7:0] OFS_PSEL = 8'h20;
	localparam logic [7:0] OFS_PROT = 8'h24;
	// ==========================================================
	// fields
	localparam int CMD_ERASE   = 0;
	localparam int CMD_PROG    = 1;
	localparam int CMD_COMMIT  = 2;
	localparam int STAT_BUSY   = 0;
	localparam int STAT_FAIL   = 1;
	localparam int STAT_PFAIL  = 2;
	localparam int INT_DONE    = 0;
	localparam int INT_ACCESS  = 1;
	localparam int INT_W       = 2;
	localparam logic [31:0] ERASED_WORD = 32'hFFFF_FFFF;
	localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;
	// ==========================================================
	// types
	typedef enum logic [1:0] {
		PROT_RW = 2'h0,
		PROT_RO = 2'h1,
		PROT_XO = 2'h2
	} prot_type;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_PULSE = 3'b010,
		ST_WIPE  = 3'b100
	} op_state_type;
	typedef struct packed {
		logic        read;
		logic        write;
		logic [7:0]  address;
		logic [31:0] writedata;
	} av_req_type;
	typedef struct packed {
		logic        req;
		logic        fetch;
		logic [31:0] addr;
	} mem_req_type;
endpackage

/* File: src/onchip_flash_ctrl.sv */
// Purpose: on-chip flash controller: erase, word program, protection, interrupt
// Assumes: one clock; registers over Avalon-MM; array read port from the core
// Notes:   committed protection survives rst_b_in, cleared only by pwr_on_b_in
// Notes on behaviour
// - erase one whole aligned 1 kB block
// - erased block reads back all ones
// - protection held per 2 kB unit
// - read-only: no erase/program, reads allowed
// - execute-only: only instruction fetch reads served
// - program one word, only ones to zeros
// - pulse time from software clocks-per-microsecond
// - flag access violation on forbidden access
// - flag completion after each erase/program
// - protection volatile until irreversible commit
// - bad or protected erase reports failure
// - per-source enables gate interrupt line
// - raw and masked status both readable
// - clear mask clears only named sources
// - status bits: completion and access violation
// - array size is build parameter
// - protection may only grow stricter
// - uncommitted protection reverts at reset
//
// Our own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ns
module onchip_flash_ctrl #(
	parameter int FLASH_KB = onchip_flash_pkg::DEF_FLASH_KB,
	parameter int ERASE_US = onchip_flash_pkg::DEF_ERASE_US,
	parameter int PROG_US  = onchip_flash_pkg::DEF_PROG_US
) (
	input  wire logic                          core_clk_in,
	input  wire logic                          rst_b_in,
	input  wire logic                          pwr_on_b_in,
	input  wire onchip_flash_pkg::av_req_type  av_in,
	output logic [31:0]                        av_readdata_out,
	output logic                               av_waitrequest_out,
	input  wire onchip_flash_pkg::mem_req_type mem_in,
	output logic [31:0]                        mem_rdata_out,
	output logic                               mem_valid_out,
	output logic                               mem_denied_out,
	output logic                               busy_out,
	output logic                               irq_out
);
	import onchip_flash_pkg::*;

	// ==========================================================
	// geometry
	localparam int WORDS      = FLASH_KB * KB_BYTES / WORD_BYTES;
	localparam int WAW        = $clog2(WORDS);
	localparam int UNITS      = FLASH_KB * KB_BYTES / UNIT_BYTES;
	localparam int UW         = (UNITS > 1) ? $clog2(UNITS) : 1;
	localparam int BLK_WORDS  = BLOCK_BYTES / WORD_BYTES;
	localparam int BW         = $clog2(BLK_WORDS);
	localparam int WSH        = $clog2(WORD_BYTES);
	localparam int BSH        = $clog2(BLOCK_BYTES);
	localparam int USH        = $clog2(UNIT_BYTES);
	localparam logic [31:0] SIZE_BYTES = 32'(FLASH_KB * KB_BYTES);
	localparam logic [15:0] ERASE_CNT  = 16'(ERASE_US);
	localparam logic [15:0] PROG_CNT   = 16'(PROG_US);

	// ==========================================================
	// state
	logic [31:0]       flash_addr, next_flash_addr;
	logic [31:0]       flash_data, next_flash_data;
	logic [7:0]        usec, next_usec;
	logic [INT_W-1:0]  int_en, next_int_en;
	logic [INT_W-1:0]  raw_int, next_raw_int;
	logic [UW-1:0]     psel, next_psel;
	logic              op_fail, next_op_fail;
	logic              prot_fail, next_prot_fail;
	op_state_type      state, next_state;
	logic              op_erase, next_op_erase;
	logic [15:0]       us_left, next_us_left;
	logic [7:0]        cyc_cnt, next_cyc_cnt;
	logic [BW-1:0]     wipe_idx, next_wipe_idx;
	logic              ack, next_ack;
	logic [31:0]       rdata, next_rdata;
	logic [31:0]       mrdata, next_mrdata;
	logic              mvalid, next_mvalid;
	logic              mdenied, next_mdenied;

	logic [31:0]       mem [WORDS];
	logic              mem_we;
	logic [WAW-1:0]    mem_wa;
	logic [31:0]       mem_wd;

	prot_type          eff [UNITS];
	logic              prot_wr;
	logic              prot_ok;
	logic              commit;
	logic              wr_take;
	logic [UW-1:0]     tgt_unit;
	logic [UW-1:0]     rd_unit;
	logic [WAW-1:0]    tgt_word;
	logic              tick;

	assign wr_take  = av_in.write & ack;
	assign tgt_unit = flash_addr[USH +: UW];
	assign tgt_word = flash_addr[WSH +: WAW];
	assign rd_unit  = mem_in.addr[USH +: UW];
	assign tick     = ({8'h00, cyc_cnt} + 16'h0001) >= {8'h00, usec};
	assign prot_wr  = wr_take & (av_in.address == OFS_PROT);
	assign commit   = wr_take & (av_in.address == OFS_CMD) & av_in.writedata[CMD_COMMIT];
	assign prot_ok  = (av_in.writedata[1:0] <= PROT_XO)
		& (av_in.writedata[1:0] >= eff[psel]);

	// ==========================================================
	// protection units: volatile part resets, committed part only at power-on
	generate
		for (genvar u = 0; u < UNITS; u++) begin : g_unit
			prot_type vol, next_vol, cmt, next_cmt;
			assign eff[u] = (vol > cmt) ? vol : cmt;
			always_comb begin
				next_vol = vol;
				next_cmt = cmt;
				if (prot_wr && prot_ok && psel == UW'(u)) begin
					next_vol = prot_type'(av_in.writedata[1:0]);
				end
				if (commit) begin
					next_cmt = eff[u];
				end
			end
			always_ff @(posedge core_clk_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					vol <= PROT_RW;
				end else begin
					vol <= next_vol;
				end
			end
			// irreversible: nothing but power-on lowers it
			always_ff @(posedge core_clk_in or negedge pwr_on_b_in) begin
				if (!pwr_on_b_in) begin
					cmt <= PROT_RW;
				end else begin
					cmt <= next_cmt;
				end
			end
		end
	endgenerate

	// ==========================================================
	// bus, operation sequencer and status
	always_comb begin
		logic set_done;
		logic set_acc;
		logic [INT_W-1:0] clr;
		set_done        = 1'b0;
		set_acc         = 1'b0;
		clr             = '0;
		next_flash_addr = flash_addr;
		next_flash_data = flash_data;
		next_usec       = usec;
		next_int_en     = int_en;
		next_psel       = psel;
		next_op_fail    = op_fail;
		next_prot_fail  = prot_fail;
		next_state      = state;
		next_op_erase   = op_erase;
		next_us_left    = us_left;
		next_cyc_cnt    = cyc_cnt;
		next_wipe_idx   = wipe_idx;
		next_ack        = (av_in.read | av_in.write) & ~ack;
		next_rdata      = rdata;
		mem_we          = 1'b0;
		mem_wa          = tgt_word;
		mem_wd          = mem[tgt_word] & flash_data;

		if (av_in.read && !ack) begin
			unique case (av_in.address)
				OFS_ADDR: next_rdata = flash_addr;
				OFS_DATA: next_rdata = flash_data;
				OFS_STAT: next_rdata = {29'h0, prot_fail, op_fail, state != ST_IDLE};
				OFS_USEC: next_rdata = {24'h0, usec};
				OFS_RAW:  next_rdata = {30'h0, raw_int};
				OFS_EN:   next_rdata = {30'h0, int_en};
				OFS_MSK:  next_rdata = {30'h0, raw_int & int_en};
				OFS_PSEL: next_rdata = 32'(psel);
				OFS_PROT: next_rdata = {30'h0, eff[psel]};
				default:  next_rdata = ZERO_WORD;
			endcase
		end

		if (wr_take) begin
			unique case (av_in.address)
				// target is frozen while busy so a running wipe cannot stray
				OFS_ADDR: if (state == ST_IDLE) begin
					next_flash_addr = av_in.writedata;
				end
				OFS_DATA: if (state == ST_IDLE) begin
					next_flash_data = av_in.writedata;
				end
				OFS_USEC: next_usec = av_in.writedata[7:0];
				OFS_EN:   next_int_en = av_in.writedata[INT_W-1:0];
				OFS_RAW:  clr = av_in.writedata[INT_W-1:0];
				OFS_PSEL: next_psel = av_in.writedata[UW-1:0];
				OFS_PROT: begin
					next_prot_fail = ~prot_ok;
				end
				default: begin
				end
			endcase
		end

		unique case (state)
			ST_IDLE: begin
				// requests while busy fall through untaken
				if (wr_take && av_in.address == OFS_CMD
						&& (av_in.writedata[CMD_ERASE] || av_in.writedata[CMD_PROG])) begin
					next_op_erase = av_in.writedata[CMD_ERASE];
					next_cyc_cnt  = 8'h00;
					next_wipe_idx = '0;
					if (flash_addr >= SIZE_BYTES
							|| (av_in.writedata[CMD_ERASE] && flash_addr[BSH-1:0] != '0)
							|| flash_addr[WSH-1:0] != '0) begin
						next_op_fail = 1'b1;
					end else if (eff[tgt_unit] != PROT_RW) begin
						next_op_fail = 1'b1;
						set_acc      = 1'b1;
					end else begin
						next_op_fail = 1'b0;
						next_state   = ST_PULSE;
						next_us_left = av_in.writedata[CMD_ERASE] ? ERASE_CNT : PROG_CNT;
					end
				end
			end
			ST_PULSE: begin
				next_cyc_cnt = tick ? 8'h00 : cyc_cnt + 8'h01;
				if (tick) begin
					next_us_left = us_left - 16'h0001;
					if (us_left <= 16'h0001) begin
						if (op_erase) begin
							next_state = ST_WIPE;
						end else begin
							mem_we     = 1'b1;
							set_done   = 1'b1;
							next_state = ST_IDLE;
						end
					end
				end
			end
			ST_WIPE: begin
				mem_we        = 1'b1;
				mem_wa        = {flash_addr[BSH +: WAW-BW], wipe_idx};
				mem_wd        = ERASED_WORD;
				next_wipe_idx = wipe_idx + BW'(1);
				if (wipe_idx == BW'(BLK_WORDS - 1)) begin
					set_done   = 1'b1;
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase

		// data reads of execute-only space and any read beyond the array are refused; in-range fetches pass
		next_mvalid  = mem_in.req;
		next_mdenied = 1'b0;
		next_mrdata  = mrdata;
		if (mem_in.req) begin
			if ((!mem_in.fetch && eff[rd_unit] == PROT_XO) || mem_in.addr >= SIZE_BYTES) begin
				next_mdenied = 1'b1;
				next_mrdata  = ZERO_WORD;
				set_acc      = 1'b1;
			end else begin
				next_mrdata = mem[mem_in.addr[WSH +: WAW]];
			end
		end

		// a new event wins over a clear in the same cycle
		next_raw_int = (raw_int & ~clr) | {set_acc, set_done};
	end

	// ==========================================================
	// registers
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			flash_addr <= ZERO_WORD;
			flash_data <= ERASED_WORD;
			usec       <= USEC_RST;
			int_en     <= '0;
			raw_int    <= '0;
			psel       <= '0;
			op_fail    <= 1'b0;
			prot_fail  <= 1'b0;
			state      <= ST_IDLE;
			op_erase   <= 1'b0;
			us_left    <= 16'h0000;
			cyc_cnt    <= 8'h00;
			wipe_idx   <= '0;
			ack        <= 1'b0;
			rdata      <= ZERO_WORD;
			mrdata     <= ZERO_WORD;
			mvalid     <= 1'b0;
			mdenied    <= 1'b0;
		end else begin
			flash_addr <= next_flash_addr;
			flash_data <= next_flash_data;
			usec       <= next_usec;
			int_en     <= next_int_en;
			raw_int    <= next_raw_int;
			psel       <= next_psel;
			op_fail    <= next_op_fail;
			prot_fail  <= next_prot_fail;
			state      <= next_state;
			op_erase   <= next_op_erase;
			us_left    <= next_us_left;
			cyc_cnt    <= next_cyc_cnt;
			wipe_idx   <= next_wipe_idx;
			ack        <= next_ack;
			rdata      <= next_rdata;
			mrdata     <= next_mrdata;
			mvalid     <= next_mvalid;
			mdenied    <= next_mdenied;
		end
	end

	// array contents are not touched by reset, like real flash cells
	always_ff @(posedge core_clk_in) begin
		if (mem_we) begin
			mem[mem_wa] <= mem_wd;
		end
	end

	// ==========================================================
	// outputs
	assign av_waitrequest_out = (av_in.read | av_in.write) & ~ack;
	assign av_readdata_out    = rdata;
	assign mem_rdata_out      = mrdata;
	assign mem_valid_out      = mvalid;
	assign mem_denied_out     = mdenied;
	assign busy_out           = state != ST_IDLE;
	assign irq_out            = |(raw_int & int_en);
endmodule // onchip_flash_ctrl

/* File: sim/onchip_flash_properties.sv */
// Purpose: port-level checker for the flash controller
// Assumes: one clock domain, reset active low
// Notes:   protection state is internal, so only port-visible relations are checked
`timescale 1ns/1ns
module onchip_flash_checker
	import onchip_flash_pkg::*;
#(
	parameter int FLASH_KB = DEF_FLASH_KB
) (
	input wire logic                          core_clk_in,
	input wire logic                          rst_b_in,
	input wire logic                          pwr_on_b_in,
	input wire onchip_flash_pkg::av_req_type  av_in,
	input wire logic [31:0]                   av_readdata_out,
	input wire logic                          av_waitrequest_out,
	input wire onchip_flash_pkg::mem_req_type mem_in,
	input wire logic [31:0]                   mem_rdata_out,
	input wire logic                          mem_valid_out,
	input wire logic                          mem_denied_out,
	input wire logic                          busy_out,
	input wire logic                          irq_out
);
	// ==========================================================
	// assertions
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);
	AST_FIRST_WAIT: assert property ($rose(av_in.read | av_in.write) |-> av_waitrequest_out)
		else $error("request not held off in its first cycle");
	AST_ONE_WAIT: assert property ((av_in.read | av_in.write) && av_waitrequest_out
		|=> !av_waitrequest_out)
		else $error("register access took more than one wait state");
	AST_VALID_NEXT: assert property (mem_in.req |=> mem_valid_out)
		else $error("array read not answered next cycle");
	AST_FETCH_SERVED: assert property (mem_in.req && mem_in.fetch
		&& mem_in.addr < FLASH_KB * KB_BYTES |=> !mem_denied_out)
		else $error("instruction fetch refused");
	AST_RANGE_DENY: assert property (mem_in.req && !mem_in.fetch
		&& mem_in.addr >= FLASH_KB * KB_BYTES |=> mem_denied_out)
		else $error("out of range data read served");
	AST_DENY_ZERO: assert property (mem_denied_out |-> mem_valid_out && mem_rdata_out == 0)
		else $error("refused read leaks data");
	AST_BUSY_CAUSE: assert property ($rose(busy_out) |-> $past(av_in.write)
		&& $past(av_in.address) == OFS_CMD)
		else $error("busy rose without a command write");
	AST_IRQ_CAUSE: assert property ($rose(irq_out) |-> $past(busy_out) || mem_denied_out
		|| $past(mem_denied_out) || $past(av_in.write))
		else $error("interrupt rose without a cause");
	AST_IRQ_CLEAR: assert property ($fell(irq_out) |-> $past(av_in.write))
		else $error("interrupt dropped without a register write");
endmodule // onchip_flash_checker

bind onchip_flash_ctrl onchip_flash_checker #(.FLASH_KB(FLASH_KB)) u_chk (
	.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .pwr_on_b_in(pwr_on_b_in),
	.av_in(av_in), .av_readdata_out(av_readdata_out),
	.av_waitrequest_out(av_waitrequest_out), .mem_in(mem_in),
	.mem_rdata_out(mem_rdata_out), .mem_valid_out(mem_valid_out),
	.mem_denied_out(mem_denied_out), .busy_out(busy_out), .irq_out(irq_out));

/* File: sim/flash_fetch_model.sv */
// Purpose: processor-side model of the array read port
// Assumes: one request at a time, answer one cycle after it is taken
// Notes:   released address is inverted so stale values never look valid
`timescale 1ns/1ns
module flash_fetch_model
	import onchip_flash_pkg::*;
(
	input  wire logic                    core_clk_in,
	input  wire logic [31:0]             mem_rdata_in,
	input  wire logic                    mem_valid_in,
	input  wire logic                    mem_denied_in,
	output onchip_flash_pkg::mem_req_type mem_out
);
	initial mem_out = '0;
	// ==========================================================
	// one word read, fetch or data
	task rd_word(input logic f, input logic [31:0] a, output logic [31:0] d, output logic dn);
		@(posedge core_clk_in);
		mem_out <= '{1'b1, f, a};
		@(posedge core_clk_in);
		mem_out <= '{1'b0, ~f, ~a};
		@(posedge core_clk_in);
		d = mem_valid_in ? mem_rdata_in : 32'hDEAD_BEEF;
		dn = mem_denied_in;
	endtask
endmodule // flash_fetch_model

/* File: sim/onchip_flash_erase_program_protect_tb.sv */
// Purpose: register-level tests of erase, program, protection and interrupts
// Assumes: short pulse parameters, one wait state per register access
// Notes:   array is not reset, so only words erased or programmed by the test are compared
`timescale 1ns/1ns
module onchip_flash_erase_program_protect_tb;
	import onchip_flash_pkg::*;
	logic                 core_clk_in = 1'b0;
	logic                 rst_b_in    = 1'b0;
	logic                 pwr_on_b_in = 1'b0;
	av_req_type           av          = '0;
	logic [31:0]          rdata, mdata, d;
	logic                 wait_req, valid, denied, busy, irq, dn;
	mem_req_type          mem;
	int                   num_errors  = 0;
	int                   n_tests     = 0;
	int                   n;
	onchip_flash_ctrl #(.FLASH_KB(8), .ERASE_US(1), .PROG_US(1)) dut (
		.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .pwr_on_b_in(pwr_on_b_in),
		.av_in(av), .av_readdata_out(rdata), .av_waitrequest_out(wait_req),
		.mem_in(mem), .mem_rdata_out(mdata), .mem_valid_out(valid),
		.mem_denied_out(denied), .busy_out(busy), .irq_out(irq));
	flash_fetch_model pm (.core_clk_in(core_clk_in), .mem_rdata_in(mdata),
		.mem_valid_in(valid), .mem_denied_in(denied), .mem_out(mem));
	initial forever #10 core_clk_in = ~core_clk_in;
	// ==========================================================
	// tasks
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk_in);
		av <= '{1'b0, 1'b1, a, v};
		do @(posedge core_clk_in); while (wait_req !== 1'b0);
		av.write <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge core_clk_in);
		av <= '{1'b1, 1'b0, a, 32'h0000_0000};
		do @(posedge core_clk_in); while (wait_req !== 1'b0);
		v = rdata;
		av.read <= 1'b0;
	endtask
	task rchk(input logic [7:0] a, input logic [31:0] exp);
		rd(a, d);
		chk($sformatf("reg %h", a), d, exp);
	endtask
	task op(input logic [31:0] a, input logic [31:0] v, input logic [31:0] c);
		wr(OFS_ADDR, a);
		wr(OFS_DATA, v);
		wr(OFS_CMD, c);
		do rd(OFS_STAT, d); while (d[STAT_BUSY] !== 1'b0);
	endtask
	task mchk(input logic f, input logic [31:0] a, input logic [31:0] exp, input logic xdn);
		pm.rd_word(f, a, d, dn);
		chk("deny", {31'h0, dn}, {31'h0, xdn});
		if (!xdn) chk("word", d, exp);
	endtask
	task reset_core;
		@(posedge core_clk_in);
		rst_b_in <= 1'b0;
		repeat (6) @(posedge core_clk_in);
		rst_b_in <= 1'b1;
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// ==========================================================
	// tests
	initial begin
		#400_000 num_errors++;
		end_of_test();
	end
	initial begin
		repeat (6) @(posedge core_clk_in);
		rst_b_in <= 1'b1;
		pwr_on_b_in <= 1'b1;
		rchk(OFS_USEC, 32'h0000_0014);
		rchk(OFS_RAW, 32'h0000_0000);
		rchk(8'hFC, 32'h0000_0000);
		wr(OFS_USEC, 32'h0000_0001);
		wr(OFS_EN, 32'h0000_0003);
		op(32'h0000_0400, 0, 32'h0000_0001);
		rchk(OFS_RAW, 32'h0000_0001);
		chk("irq", {31'h0, irq}, 32'h0000_0001);
		mchk(1'b0, 32'h0000_0400, ERASED_WORD, 1'b0);
		mchk(1'b0, 32'h0000_07FC, ERASED_WORD, 1'b0);
		op(32'h0000_0400, 32'h1234_5678, 32'h0000_0002);
		op(32'h0000_0400, 32'hFF00_FFFF, 32'h0000_0002);
		mchk(1'b1, 32'h0000_0400, 32'h1200_5678, 1'b0);
		op(32'h0000_0404, 0, 32'h0000_0001);
		rchk(OFS_STAT, 32'h0000_0002);
		mchk(1'b0, 32'h0000_2000, 0, 1'b1);
		wr(OFS_USEC, 32'h0000_0003);
		wr(OFS_ADDR, 32'h0000_0404);
		wr(OFS_CMD, 32'h0000_0002);
		n = 0;
		#1;
		repeat (10) begin
			if (busy) n++;
			@(posedge core_clk_in);
			#1;
		end
		chk("busy span", n, 32'h0000_0003);
		wr(OFS_USEC, 32'h0000_0001);
		wr(OFS_ADDR, 32'h0000_0400);
		wr(OFS_CMD, 32'h0000_0001);
		wr(OFS_CMD, 32'h0000_0002);
		op(32'h0000_0400, 0, 0);
		mchk(1'b0, 32'h0000_0400, ERASED_WORD, 1'b0);
		op(32'h0000_0800, 0, 32'h0000_0001);
		wr(OFS_RAW, 32'h0000_0003);
		wr(OFS_EN, 32'h0000_0001);
		wr(OFS_PSEL, 32'h0000_0001);
		wr(OFS_PROT, {30'h0, PROT_RO});
		rchk(OFS_PROT, 32'h0000_0001);
		op(32'h0000_0800, 0, 32'h0000_0002);
		rchk(OFS_STAT, 32'h0000_0002);
		rchk(OFS_RAW, 32'h0000_0002);
		rchk(OFS_MSK, 32'h0000_0000);
		chk("irq", {31'h0, irq}, 32'h0000_0000);
		mchk(1'b0, 32'h0000_0800, ERASED_WORD, 1'b0);
		wr(OFS_EN, 32'h0000_0003);
		rchk(OFS_MSK, 32'h0000_0002);
		wr(OFS_RAW, 32'h0000_0001);
		rchk(OFS_RAW, 32'h0000_0002);
		wr(OFS_PROT, {30'h0, PROT_RW});
		rchk(OFS_STAT, 32'h0000_0006);
		rchk(OFS_PROT, 32'h0000_0001);
		wr(OFS_PROT, {30'h0, PROT_XO});
		mchk(1'b0, 32'h0000_0800, 0, 1'b1);
		mchk(1'b1, 32'h0000_0800, ERASED_WORD, 1'b0);
		wr(OFS_PROT, 32'h0000_0003);
		rchk(OFS_STAT, 32'h0000_0006);
		rchk(OFS_PROT, 32'h0000_0002);
		wr(OFS_PSEL, 32'h0000_0000);
		rchk(OFS_PROT, 32'h0000_0000);
		reset_core();
		wr(OFS_PSEL, 32'h0000_0001);
		rchk(OFS_PROT, 32'h0000_0000);
		wr(OFS_PSEL, 32'h0000_0002);
		wr(OFS_PROT, {30'h0, PROT_RO});
		wr(OFS_CMD, 32'h0000_0004);
		reset_core();
		wr(OFS_PSEL, 32'h0000_0002);
		rchk(OFS_PROT, 32'h0000_0001);
		end_of_test();
	end
endmodule // onchip_flash_erase_program_protect_tb
